// ===== standby_regs.svh
`ifndef STANDBY_REGS_SVH
`define STANDBY_REGS_SVH

// Command opcodes
`define OP_STANDBY      8'hE2
`define OP_STANDBY_ALT  8'h96
`define OP_STBY_IMM     8'hE0
`define OP_STBY_IMM_ALT 8'h94

// Timeout code boundaries
`define TO_DISABLED     8'h00
`define TO_SHORT_MAX    8'hF0
`define TO_LONG_MAX     8'hFB
`define TO_21MIN        8'hFC
`define TO_8HOUR        8'hFD
`define TO_ABORT        8'hFE

// Intervals in seconds
`define SEC_STEP_SHORT  16'h0005
`define SEC_STEP_LONG   16'h0708
`define SEC_21MIN       16'h04EC
`define SEC_8HOUR       16'h7080
`define SEC_21MIN15     16'h04FB
`define SEC_ZERO        16'h0000
`define SEC_ONE         16'h0001

// Completion values
`define STAT_OK         8'h50
`define STAT_ERR        8'h51
`define ERR_NONE        8'h00
`define ERR_ABT         8'h04

// Timing
`define SECOND_NS       32'h3B9A_CA00
`define CLK_PERIOD_NS   32'h0000_0064
`define PRESCALE_ZERO   24'h00_0000
`define PRESCALE_ONE    24'h00_0001

`endif

// ===== standby_pkg.sv
package standby_pkg;

  typedef enum logic [1:0] {
    PWR_IDLE      = 2'h0,
    PWR_SPIN_DOWN = 2'h1,
    PWR_STANDBY   = 2'h3,
    PWR_SPIN_UP   = 2'h2
  } pwr_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] count;
  } cmd_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
  } result_t;

endpackage

// ===== standby_power_ctrl.sv
`timescale 1ns/1ps
`include "standby_regs.svh"
// Overview of operation
// - Standby: enter standby, store timeout code
// - Immediate standby: enter standby, keep timeout
// - Spin down unless spindle already stopped
// - Standby accepts commands, holds until spun up
// - Timer counts only after return to idle
// - Codes 0 off, 1-240 x5s, 241-251 x30min
// - 252 21min, 253 8h, 255 21m15s, 254 aborts
// - Armed timer expiry enters standby automatically
// - Host access reloads full timer interval
// - Extended power enabled: standby becomes Standby_Z
module standby_power_ctrl #(
  parameter int unsigned TICK_CYCLES = `SECOND_NS / `CLK_PERIOD_NS
) (
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   cmd_valid_in,
  input  wire standby_pkg::cmd_t      cmd_in,
  input  wire logic                   host_access_in,
  input  wire logic                   epc_enable_in,
  input  wire logic                   spindle_stopped_in,
  input  wire logic                   spindle_at_speed_in,
  output standby_pkg::pwr_state_t     power_state_out,
  output logic                        spin_down_out,
  output logic                        motor_run_out,
  output logic                        cmd_hold_out,
  output logic                        busy_out,
  output logic                        standby_z_out,
  output logic                        done_out,
  output standby_pkg::result_t        result_out
);

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

  standby_pkg::pwr_state_t state_r;
  standby_pkg::pwr_state_t state_nxt;
  logic [7:0]  code_r;
  logic [15:0] secs_r;
  logic [23:0] pre_r;
  logic        epc_r;
  logic        pend_r;

  wire is_std   = cmd_valid_in && (cmd_in.opcode == `OP_STANDBY ||
                                   cmd_in.opcode == `OP_STANDBY_ALT);
  wire is_imm   = cmd_valid_in && (cmd_in.opcode == `OP_STBY_IMM ||
                                   cmd_in.opcode == `OP_STBY_IMM_ALT);
  wire std_bad  = is_std && cmd_in.count == `TO_ABORT;
  wire std_ok   = is_std && !std_bad;
  wire other    = cmd_valid_in && !is_std && !is_imm;
  wire in_idle  = state_r == standby_pkg::PWR_IDLE;
  wire powered  = state_r == standby_pkg::PWR_IDLE || state_r == standby_pkg::PWR_SPIN_UP;

  // Interval in seconds for the stored code
  wire [7:0]  c         = code_r;
  wire [15:0] short_sec = 16'(c * `SEC_STEP_SHORT);
  wire [15:0] long_sec  = 16'((c - `TO_SHORT_MAX) * `SEC_STEP_LONG);
  wire [15:0] interval =
    (c == `TO_DISABLED)  ? `SEC_ZERO  :
    (c <= `TO_SHORT_MAX) ? short_sec  :
    (c <= `TO_LONG_MAX)  ? long_sec   :
    (c == `TO_21MIN)     ? `SEC_21MIN :
    (c == `TO_8HOUR)     ? `SEC_8HOUR : `SEC_21MIN15;
  wire armed   = interval != `SEC_ZERO;
  wire tick    = pre_r == TICK_LAST;
  // Timer idles loaded outside idle so it starts fresh on return
  wire run     = in_idle && armed && !std_ok && !is_imm;
  wire reload  = !run || host_access_in || cmd_valid_in;
  wire expire  = run && !reload && tick && secs_r == `SEC_ONE;
  wire go_stby = std_ok || is_imm || expire;
  wire wake    = other && !powered;
  wire stopped_tgt = spindle_stopped_in;
  standby_pkg::pwr_state_t down_tgt;
  assign down_tgt = stopped_tgt ? standby_pkg::PWR_STANDBY
                                : standby_pkg::PWR_SPIN_DOWN;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      standby_pkg::PWR_IDLE: begin
        if (go_stby) state_nxt = down_tgt;
      end
      standby_pkg::PWR_SPIN_DOWN: begin
        if (go_stby) state_nxt = down_tgt;
        else if (wake) state_nxt = standby_pkg::PWR_SPIN_UP;
        else if (spindle_stopped_in) state_nxt = standby_pkg::PWR_STANDBY;
      end
      standby_pkg::PWR_STANDBY: begin
        if (wake) state_nxt = standby_pkg::PWR_SPIN_UP;
      end
      standby_pkg::PWR_SPIN_UP: begin
        if (go_stby) state_nxt = down_tgt;
        else if (spindle_at_speed_in) state_nxt = standby_pkg::PWR_IDLE;
      end
    endcase
  end

  wire nxt_low  = state_nxt == standby_pkg::PWR_SPIN_DOWN ||
                  state_nxt == standby_pkg::PWR_STANDBY;
  wire reach_sb = state_nxt == standby_pkg::PWR_STANDBY;
  wire hold_nxt = (cmd_hold_out || wake) && state_nxt != standby_pkg::PWR_IDLE;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_r <= standby_pkg::PWR_IDLE;
      code_r  <= `TO_DISABLED;
      epc_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (std_ok) code_r <= cmd_in.count;
      if (go_stby) epc_r <= epc_enable_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pre_r  <= `PRESCALE_ZERO;
      secs_r <= `SEC_ZERO;
    end else if (reload) begin
      pre_r  <= `PRESCALE_ZERO;
      secs_r <= interval;
    end else if (tick) begin
      pre_r  <= `PRESCALE_ZERO;
      secs_r <= secs_r - `SEC_ONE;
    end else begin
      pre_r  <= pre_r + `PRESCALE_ONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pend_r        <= 1'b0;
      done_out      <= 1'b0;
      result_out    <= '0;
      spin_down_out <= 1'b0;
      motor_run_out <= 1'b1;
      cmd_hold_out  <= 1'b0;
      busy_out      <= 1'b0;
      standby_z_out <= 1'b0;
    end else begin
      pend_r        <= (pend_r || std_ok || is_imm) && !reach_sb;
      done_out      <= std_bad || ((pend_r || std_ok || is_imm) && reach_sb);
      if (std_bad) result_out <= '{status: `STAT_ERR, error: `ERR_ABT};
      // Only an abort or a completion updates the result, so an abort stays visible until the next completion
      else if ((pend_r || std_ok || is_imm) && reach_sb)
        result_out <= '{status: `STAT_OK, error: `ERR_NONE};
      spin_down_out <= state_nxt == standby_pkg::PWR_SPIN_DOWN;
      motor_run_out <= !nxt_low;
      cmd_hold_out  <= hold_nxt;
      busy_out      <= (pend_r || std_ok || is_imm) && !reach_sb;
      standby_z_out <= reach_sb && (go_stby ? epc_enable_in : epc_r);
    end
  end

  assign power_state_out = state_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_std_stores_code: assert property (std_ok |=> code_r == $past(cmd_in.count))
    else $error("standby did not store timeout code");
  a_imm_keeps_code: assert property (is_imm && !is_std |=> $stable(code_r))
    else $error("immediate standby changed timeout code");
  a_skip_spindown: assert property (is_imm && spindle_stopped_in
                                    |=> state_r == standby_pkg::PWR_STANDBY && !spin_down_out)
    else $error("spin down not skipped");
  a_spin_down_req: assert property (in_idle && is_imm && !spindle_stopped_in
                                    |=> spin_down_out && !motor_run_out)
    else $error("spin down not requested");
  a_wake_holds: assert property (state_r == standby_pkg::PWR_STANDBY && wake
                                 |=> cmd_hold_out && motor_run_out)
    else $error("command in standby not held");
  a_hold_release: assert property (state_r == standby_pkg::PWR_SPIN_UP
                                   && spindle_at_speed_in && !go_stby
                                   |=> state_r == standby_pkg::PWR_IDLE && !cmd_hold_out)
    else $error("hold not released at speed");
  a_timer_frozen: assert property (!in_idle |=> secs_r == $past(interval))
    else $error("timer ran outside idle");
  a_decode_short: assert property (code_r == 8'h0C |-> interval == 16'h003C)
    else $error("short code decode wrong");
  a_decode_long: assert property (code_r == 8'hF3 |-> interval == 16'h1518)
    else $error("long code decode wrong");
  a_decode_fixed: assert property (code_r == 8'hFF |-> interval == 16'h04FB)
    else $error("fixed code decode wrong");
  a_expire_down: assert property (expire |=> state_r != standby_pkg::PWR_IDLE)
    else $error("expiry did not enter standby");
  a_access_reload: assert property (host_access_in |=> secs_r == $past(interval)
                                    && pre_r == `PRESCALE_ZERO)
    else $error("host access did not reload timer");
  a_epc_z: assert property ((std_ok || is_imm) && epc_enable_in && spindle_stopped_in
                            |=> standby_z_out)
    else $error("standby_z not entered");
  a_abort_result: assert property (std_bad |=> done_out && !busy_out
                                   && result_out.error == `ERR_ABT
                                   && result_out.status[0] && !result_out.status[7])
    else $error("aborted code result wrong");

  c_auto_standby: cover property (expire);
  c_wake_cycle: cover property (state_r == standby_pkg::PWR_STANDBY && wake
                                ##[1:20] state_r == standby_pkg::PWR_IDLE);
  c_spin_down: cover property (spin_down_out ##[1:20] state_r == standby_pkg::PWR_STANDBY);
  c_abort: cover property (std_bad);

endmodule // standby_power_ctrl

// ===== spindle_model.sv
`timescale 1ns/1ps
module spindle_model #(
  parameter int DLY = 5
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic spin_down_in,
  input  wire logic motor_run_in,
  output logic      stopped_out,
  output logic      at_speed_out
);
  logic [3:0] cnt_r;
  logic       dir_r;
  wire        at_end = (cnt_r == 4'(DLY));
  // Spin-up raises at_speed DLY+1 cycles after motor run; spin-down raises stopped on its first edge, from the count left at DLY
  always_ff @(posedge clk_in) begin
    dir_r <= spin_down_in;
    if (!rstn_in || spin_down_in != dir_r) begin
      cnt_r <= 4'h0;
    end else if ((spin_down_in || motor_run_in) && !at_end) begin
      cnt_r <= cnt_r + 4'h1;
    end
    if (!rstn_in) begin
      stopped_out  <= 1'b0;
      at_speed_out <= 1'b0;
    end else if (spin_down_in) begin
      at_speed_out <= 1'b0;
      stopped_out  <= at_end;
    end else if (motor_run_in) begin
      stopped_out  <= 1'b0;
      at_speed_out <= at_end;
    end
  end
endmodule // spindle_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int TICK = 4;
  logic clk_in = 0, rstn_in = 0, cmd_valid_in = 0, host_access_in = 0, epc_enable_in = 0;
  logic stopped, at_speed, spin_down, motor_run, hold, busy, stz, done;
  standby_pkg::cmd_t       cmd_in = '0;
  standby_pkg::pwr_state_t st;
  standby_pkg::result_t    res;
  standby_pkg::result_t    exp_q[$];
  int n_mismatch = 0, comparisons = 0;
  always #50 clk_in = ~clk_in;
  standby_power_ctrl #(.TICK_CYCLES(TICK)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .host_access_in(host_access_in),
    .epc_enable_in(epc_enable_in), .spindle_stopped_in(stopped),
    .spindle_at_speed_in(at_speed), .power_state_out(st), .spin_down_out(spin_down),
    .motor_run_out(motor_run), .cmd_hold_out(hold), .busy_out(busy),
    .standby_z_out(stz), .done_out(done), .result_out(res));
  spindle_model spin_u (.clk_in(clk_in), .rstn_in(rstn_in), .spin_down_in(spin_down),
    .motor_run_in(motor_run), .stopped_out(stopped), .at_speed_out(at_speed));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Count is set up together with the opcode, never after it
  task automatic send(logic [7:0] op, logic [7:0] cnt);
    @(posedge clk_in);
    cmd_in       <= '{opcode: op, count: cnt};
    cmd_valid_in <= 1'b1;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
  endtask
  task automatic wait_st(standby_pkg::pwr_state_t s, int n);
    for (int i = 0; i < n && st !== s; i++) @(posedge clk_in) #1;
    check("power state", 16'(st), 16'(s));
  endtask
  task automatic go_standby(logic [7:0] op, logic [7:0] cnt);
    exp_q.push_back(16'h5000);
    send(op, cnt);
    #1 check("spin down", 16'(spin_down), 16'h0001);
    check("motor run", 16'(motor_run), 16'h0000);
    check("busy", 16'(busy), 16'h0001);
    wait_st(standby_pkg::PWR_STANDBY, 20);
  endtask
  task automatic wake();
    send(8'hE8, 8'h00);
    #1 check("held", 16'(hold), 16'h0001);
    wait_st(standby_pkg::PWR_IDLE, 20);
    check("held", 16'(hold), 16'h0000);
  endtask
  task automatic endt(string name);
    repeat (3) @(posedge clk_in);
    check("pending results", 16'(exp_q.size()), 16'h0000);
    $display("test %s done", name);
  endtask
  // Results are matched in order against what each command should produce
  always @(negedge clk_in) begin
    if (done === 1'b1 && exp_q.size() > 0) check("result", res, exp_q.pop_front());
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end
  logic [7:0] ops [2] = '{8'h96, 8'h94};
  initial begin
    void'($urandom(32'hb8d8));
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    wait_st(standby_pkg::PWR_IDLE, 2);
    repeat (8) @(posedge clk_in);
    foreach (ops[i]) begin
      go_standby(ops[i], (i == 0) ? 8'h00 : 8'($urandom()));
      check("standby z", 16'(stz), 16'h0000);
      wake();
    end
    endt("alt opcodes");
    exp_q.push_back(16'h5104);
    send(8'hE2, 8'hFE);
    repeat (2) @(posedge clk_in);
    #1 check("abort state", 16'(st), 16'(standby_pkg::PWR_IDLE));
    endt("abort code");
    epc_enable_in <= 1'b1;
    go_standby(8'hE2, 8'h01);
    check("standby z", 16'(stz), 16'h0001);
    exp_q.push_back(16'h5000);
    send(8'hE2, 8'h01);
    #1 check("no spin down", 16'(st), 16'(standby_pkg::PWR_STANDBY));
    check("standby z kept", 16'(stz), 16'h0001);
    epc_enable_in <= 1'b0;
    endt("epc and stopped");
    wake();
    go_standby(8'hE0, 8'($urandom_range(8'hF0, 8'h01)));
    wake();
    endt("immediate keeps code");
    // Code 1 means 5 s, i.e. 5 * TICK idle cycles
    repeat (5 * TICK - 8) @(posedge clk_in);
    #1 check("timer early", 16'(st), 16'(standby_pkg::PWR_IDLE));
    host_access_in <= 1'b1;
    @(posedge clk_in);
    host_access_in <= 1'b0;
    repeat (5 * TICK - 4) @(posedge clk_in);
    #1 check("timer reload", 16'(st), 16'(standby_pkg::PWR_IDLE));
    repeat (4) @(posedge clk_in);
    #1 check("timer expiry", 16'(st), 16'(standby_pkg::PWR_SPIN_DOWN));
    wait_st(standby_pkg::PWR_STANDBY, 20);
    endt("auto power down");
    close_out();
  end
endmodule // testbench
